/* File: osc_source_switch_tb.sv */
/*
  Testbench for the oscillator source switch: pin set-up per option, edge
  count before change-over, change-over order and stickiness.
  Assumes oss_switch and the external source model.
*/
`timescale 1ns/100ps
`default_nettype none
module osc_source_switch_tb;
  import oss_pkg::*;
  logic       clk_sys_i;
  logic       rst_n_i;
  oss_ctrl_s  ctrl;
  logic       port_out;
  logic       port_oe;
  logic       go;
  logic [3:0] edges;
  logic       ext_pin;
  oss_stat_s  stat;
  oss_pin_s   pin;
  logic [7:0] trim;
  logic       cout;
  logic       coe;
  int         err_total;
  int         n_checks;

  oss_switch DUT (
    .clk_sys_i         (clk_sys_i),
    .rst_n_i           (rst_n_i),
    .ctrl_i            (ctrl),
    .clock_in_pin_i    (ext_pin),
    .port_out_i        (port_out),
    .port_oe_i         (port_oe),
    .stat_o            (stat),
    .pin_o             (pin),
    .trim_o            (trim),
    .clock_out_pin_o   (cout),
    .clock_out_pin_oe_o(coe)
  );
  oss_ext_src_model src (
    .go_i   (go),
    .edges_i(edges),
    .pin_o  (ext_pin)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    rst_n_i = 1'b0;
    ctrl = '0;
    ctrl.trim = OSS_TRIM_RESET;
    go = 1'b0;
    cyc(16);
    rst_n_i = 1'b1;
    cyc(1);
  endtask
  task automatic write_option(input logic [1:0] opt);
    ctrl.clock_source_option = opt;
    ctrl.option_written = 1'b1;
    cyc(1);
    ctrl.option_written = 1'b0;
    cyc(2);
  endtask
  task automatic burst(input logic [3:0] n);
    edges = n;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_trim;
    chk(8'(stat), 8'h2, "reset status");
    chk(trim, OSS_TRIM_RESET, "reset trim");
    ctrl.trim = OSS_TRIM_RESET + 8'h1;
    cyc(3);
    chk(trim, OSS_TRIM_RESET + 8'h1, "trim step");
  endtask
  task automatic t_options;
    logic [1:0] o;
    for (int i = 1; i < 4; i++) begin
      o = 2'(i);
      do_reset();
      port_out = 1'b0;
      port_oe = 1'b1;
      write_option(o);
      chk(8'(pin), {4'h0, 1'b1, o == 2'h3, o == 2'h2, o == 2'h3}, "pins");
      chk(8'({cout, coe}), {6'h0, o == 2'h3, 1'b1}, "out pin");
    end
  endtask
  task automatic t_crystal_switch;
    int k;
    do_reset();
    port_out = 1'b1;
    port_oe = 1'b1;
    cyc(4);
    chk(8'({cout, coe}), 8'h3, "precharge");
    write_option(OSS_OPT_CRYSTAL);
    chk(8'(pin), 8'hd, "xtal pins");
    cyc(20);
    ctrl.ext_clock_on = 1'b1;
    cyc(2);
    chk(8'(stat.ext_clock_on), 8'h1, "gen on");
    cyc(40);
    chk(8'(stat), 8'ha, "no edges");
    burst(4'h1);
    cyc(30);
    chk(8'(stat), 8'ha, "one edge");
    burst(4'h1);
    k = 0;
    while (stat.ext_clock_engaged !== 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    if (k == 60) begin
      err_total++;
      report_and_stop();
    end
    chk(8'(stat), 8'hf, "engaged first");
    cyc(1);
    chk(8'(stat), 8'hd, "internal off");
    ctrl.ext_clock_on = 1'b0;
    write_option(OSS_OPT_RC);
    cyc(50);
    chk(8'(stat), 8'hd, "sticky");
    chk(8'(pin), 8'hd, "option refused");
  endtask
  task automatic t_refused;
    do_reset();
    chk(8'(stat), 8'h2, "reset after external");
    ctrl.ext_clock_on = 1'b1;
    cyc(3);
    burst(4'h2);
    cyc(30);
    chk(8'(stat), 8'h2, "request without option");
    ctrl.ext_clock_on = 1'b0;
    write_option(OSS_OPT_INTERNAL);
    ctrl.ext_clock_on = 1'b1;
    burst(4'h2);
    cyc(30);
    chk(8'(stat), 8'h2, "request with internal option");
    chk(8'(pin), 8'h0, "internal pins");
    ctrl.ext_clock_on = 1'b0;
  endtask

  initial begin
    err_total = 0;
    n_checks = 0;
    port_out = 1'b0;
    port_oe = 1'b0;
    edges = 4'h0;
    do_reset();
    t_reset_trim();
    t_options();
    t_crystal_switch();
    t_refused();
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: oss_edge_sync.sv */
/*
  Two-flop synchroniser with rising edge detect for the external clock.
  Assumes the input is asynchronous to clk_sys_i and at most clk/4 fast.
*/
`timescale 1ns/100ps
`default_nettype none
module oss_edge_sync (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
endmodule
`default_nettype wire

/* File: oss_ext_src_model.sv */
/*
  External clock source model: emits a burst of rising edges on the clock
  input pin each time go_i rises. Assumes the bench sets edges_i first.
*/
`timescale 1ns/100ps
`default_nettype none
module oss_ext_src_model (
  input  wire logic       go_i,
  input  wire logic [3:0] edges_i,
  output var logic        pin_o
);
  // ----------------------------------------
  // Burst generator
  // ----------------------------------------
  // settled source only
  // The pin rests low between bursts, as a stopped source does
  initial begin
    pin_o = 1'b0;
    forever begin
      @(posedge go_i);
      #7;
      repeat (edges_i) begin
        #80 pin_o = 1'b1;
        #80 pin_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: oss_pkg.sv */
/*
  Package for the oscillator source switch: source option codes, trim
  layout, switch-over states and the struct types that carry control and
  status between the switch and its surroundings.
  Assumes a single 50 MHz system clock.
*/
package oss_pkg;

  // Source option codes
  localparam logic [1:0] OSS_OPT_INTERNAL = 2'h0;
  localparam logic [1:0] OSS_OPT_EXTCLK   = 2'h1;
  localparam logic [1:0] OSS_OPT_RC       = 2'h2;
  localparam logic [1:0] OSS_OPT_CRYSTAL  = 2'h3;

  // Trim field
  localparam int         OSS_TRIM_W     = 8;
  localparam logic [7:0] OSS_TRIM_RESET = 8'h80;

  // Rising edges of the external clock needed before change-over
  localparam int         OSS_EDGES_NEEDED = 2;

  // Timing
  localparam int OSS_CLK_SYS_MHZ   = 50;
  localparam int OSS_LINK_PERIOD_NS = 160;

  typedef enum logic [1:0] {
    OSS_ST_INTERNAL,
    OSS_ST_WAIT_EDGES,
    OSS_ST_SWITCH,
    OSS_ST_EXTERNAL
  } oss_state_e;

  typedef struct packed {
    logic [1:0]            clock_source_option;
    logic                  option_written;
    logic                  ext_clock_on;
    logic [OSS_TRIM_W-1:0] trim;
  } oss_ctrl_s;

  typedef struct packed {
    logic ext_clock_on;
    logic ext_clock_engaged;
    logic int_osc_enable;
    logic use_external;
  } oss_stat_s;

  typedef struct packed {
    logic clock_in_is_input;
    logic clock_out_drives;
    logic rc_osc_enable;
    logic xtal_osc_enable;
  } oss_pin_s;

endpackage

/* File: oss_switch.sv */
/*
  Oscillator source switch. Holds the internal oscillator after reset,
  sets up pins for the chosen source, and on request confirms two rising
  edges of the external clock before a glitch-free change-over.
  Assumes software control arrives as plain inputs on clk_sys_i and that
  clock_in_pin_i is asynchronous.
*/
// Notes on behaviour
// - After reset the internal oscillator is the running source.
// - The internal oscillator is tuned by an 8-bit trim, about 0.2% per step.
// - External clock mode takes a clock straight into the clock input pin.
// - RC mode enables the built-in RC oscillator on one pin.
// - Crystal mode enables the built-in crystal oscillator on two pins.
// - Writing a non-internal option makes the input pin a clock input, and the output pin too in crystal mode.
// - After the request the block waits for two external rising edges.
// - The system clock then moves to the external source without a glitch.
// - The engaged bit is set first and the internal oscillator stopped after.
// - Once external, the internal oscillator stays off until reset.
// - A stopped external clock does not cause a return to internal.
// - The external-clock-on status reads 1 from an accepted request until reset.
// - The engaged status reads 1 while the external source drives the clock.
`timescale 1ns/100ps
`default_nettype none
module oss_switch (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire oss_pkg::oss_ctrl_s ctrl_i,
  input  wire logic              clock_in_pin_i,
  input  wire logic              port_out_i,
  input  wire logic              port_oe_i,
  output oss_pkg::oss_stat_s     stat_o,
  output oss_pkg::oss_pin_s      pin_o,
  output logic [7:0]             trim_o,
  output logic                   clock_out_pin_o,
  output logic                   clock_out_pin_oe_o
);
  import oss_pkg::*;

  oss_state_e  state_q;
  logic [1:0]  opt_q;
  logic        opt_valid_q;
  logic [1:0]  edge_cnt_q;
  logic        engaged_q;
  logic        int_en_q;
  logic        use_ext_q;
  logic        gen_on_q;
  logic [7:0]  trim_q;
  oss_pin_s    pin_q;
  logic        out_q;
  logic        oe_q;
  logic        ext_level;
  logic        ext_rise;

  // ---------------------------------------------------------------
  // External clock sampling
  // ---------------------------------------------------------------
  oss_edge_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (clock_in_pin_i),
    .level_o   (ext_level),
    .rise_o    (ext_rise)
  );

  // ---------------------------------------------------------------
  // Option capture and trim
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_q       <= OSS_OPT_INTERNAL;
      opt_valid_q <= 1'b0;
      trim_q      <= OSS_TRIM_RESET;
    end else begin
      trim_q <= ctrl_i.trim;
      // Source is frozen once the change-over starts
      if (ctrl_i.option_written && state_q == OSS_ST_INTERNAL) begin
        opt_q       <= ctrl_i.clock_source_option;
        opt_valid_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin setup
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= '0;
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      pin_q.clock_in_is_input <= opt_valid_q && opt_q != OSS_OPT_INTERNAL;
      pin_q.clock_out_drives  <= opt_valid_q && opt_q == OSS_OPT_CRYSTAL;
      pin_q.rc_osc_enable     <= opt_valid_q && opt_q == OSS_OPT_RC;
      pin_q.xtal_osc_enable   <= opt_valid_q && opt_q == OSS_OPT_CRYSTAL;
      // port drive until crystal takes the pin
      if (opt_valid_q && opt_q == OSS_OPT_CRYSTAL) begin
        out_q <= 1'b1;
        oe_q  <= 1'b1;
      end else begin
        out_q <= port_out_i;
        oe_q  <= port_oe_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Change-over sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q    <= OSS_ST_INTERNAL;
      edge_cnt_q <= 2'h0;
      gen_on_q   <= 1'b0;
    end else begin
      unique case (state_q)
        OSS_ST_INTERNAL: begin
          edge_cnt_q <= 2'h0;
          if (ctrl_i.ext_clock_on && opt_valid_q && opt_q != OSS_OPT_INTERNAL) begin
            gen_on_q <= 1'b1;
            state_q  <= OSS_ST_WAIT_EDGES;
          end
        end
        OSS_ST_WAIT_EDGES: begin
          // count two rises, wait forever otherwise
          if (ext_rise) begin
            if (edge_cnt_q == 2'(OSS_EDGES_NEEDED - 1)) begin
              state_q <= OSS_ST_SWITCH;
            end
            edge_cnt_q <= edge_cnt_q + 2'h1;
          end
        end
        OSS_ST_SWITCH: begin
          // wait for low phase before handing over
          if (!ext_level) begin
            state_q <= OSS_ST_EXTERNAL;
          end
        end
        OSS_ST_EXTERNAL: begin
          state_q <= OSS_ST_EXTERNAL;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Clock select and status
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      use_ext_q <= 1'b0;
      engaged_q <= 1'b0;
      int_en_q  <= 1'b1;
    end else begin
      // select changes only while the synchronised external clock is low
      if (state_q == OSS_ST_SWITCH && !ext_level) begin
        use_ext_q <= 1'b1;
      end
      // engaged one cycle after select, then stop internal
      if (use_ext_q) begin
        engaged_q <= 1'b1;
      end
      if (engaged_q) begin
        int_en_q <= 1'b0;
      end
    end
  end

  assign stat_o = '{ext_clock_on:      gen_on_q,
                    ext_clock_engaged: engaged_q,
                    int_osc_enable:    int_en_q,
                    use_external:      use_ext_q};
  assign pin_o                    = pin_q;
  assign trim_o                   = trim_q;
  assign clock_out_pin_o          = out_q;
  assign clock_out_pin_oe_o       = oe_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_req;
    state_q == OSS_ST_INTERNAL && ctrl_i.ext_clock_on && opt_valid_q
      && opt_q != OSS_OPT_INTERNAL;
  endsequence

  sequence s_engage;
    use_ext_q ##1 engaged_q ##1 !int_en_q;
  endsequence

  property p_reset_internal;
    @(posedge clk_sys_i) $rose(rst_n_i) |-> int_en_q && !use_ext_q;
  endproperty
  a_reset_internal: assert property (p_reset_internal)
    else $error("internal oscillator not running after reset");

  property p_trim;
    @(posedge clk_sys_i) disable iff (!rst_n_i) ##1 trim_q == $past(ctrl_i.trim);
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim not applied");

  property p_xtal_pins;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      opt_valid_q && opt_q == OSS_OPT_CRYSTAL |=> pin_q.clock_out_drives
        && pin_q.xtal_osc_enable && pin_q.clock_in_is_input;
  endproperty
  a_xtal_pins: assert property (p_xtal_pins)
    else $error("crystal pins not set up");

  property p_rc_pin;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      opt_valid_q && opt_q == OSS_OPT_RC |=> pin_q.rc_osc_enable && !pin_q.clock_out_drives;
  endproperty
  a_rc_pin: assert property (p_rc_pin)
    else $error("rc pin not set up");

  property p_gen_on;
    @(posedge clk_sys_i) disable iff (!rst_n_i) s_req |=> gen_on_q;
  endproperty
  a_gen_on: assert property (p_gen_on)
    else $error("generator on not shown");

  property p_no_early_switch;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == OSS_ST_WAIT_EDGES && !ext_rise |=> !use_ext_q;
  endproperty
  a_no_early_switch: assert property (p_no_early_switch)
    else $error("switched before two edges");

  property p_engaged_needs_ext;
    @(posedge clk_sys_i) disable iff (!rst_n_i) engaged_q |-> use_ext_q;
  endproperty
  a_engaged_needs_ext: assert property (p_engaged_needs_ext)
    else $error("engaged without external clock");

  property p_order;
    @(posedge clk_sys_i) disable iff (!rst_n_i) $rose(use_ext_q) |-> s_engage;
  endproperty
  a_order: assert property (p_order)
    else $error("engage order wrong");

  property p_sticky;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !int_en_q |=> !int_en_q && use_ext_q && state_q == OSS_ST_EXTERNAL;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("internal oscillator restarted");

  property p_glitch_free;
    @(posedge clk_sys_i) disable iff (!rst_n_i) $rose(use_ext_q) |-> !$past(ext_level);
  endproperty
  a_glitch_free: assert property (p_glitch_free)
    else $error("select changed while external clock high");

  property p_stay_internal;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == OSS_ST_INTERNAL |-> !engaged_q && int_en_q;
  endproperty
  a_stay_internal: assert property (p_stay_internal)
    else $error("engaged without confirmation");

endmodule
`default_nettype wire
